// >>> dac_port_pkg.sv
// Constants, command layout and states of the converter serial control port
`default_nettype none
package dac_port_pkg;
	// Clock and acquisition timing
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned ACQ_ONE_US    = 16;
	localparam int unsigned ACQ_ALL_US    = 45;
	localparam int unsigned ACQ_ONE_CYCLES = (ACQ_ONE_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned ACQ_ALL_CYCLES_DEF = (ACQ_ALL_US * 1000) / CLK_PERIOD_NS;

	// Serial word lengths, as last-bit counts
	localparam int unsigned CODE_BITS = 14;
	localparam logic [4:0]  CMD_LAST  = 5'h09;
	localparam logic [4:0]  LOAD_LAST = 5'h17;
	localparam logic [4:0]  READ_LAST = 5'h0D;

	// Channel indices
	localparam int unsigned NUM_CONV  = 32;
	localparam int unsigned NUM_REGS  = 33;
	localparam logic [5:0]  OFFSET_CH = 6'h20;

	// Register map and reset values
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATUS = 8'h04;
	localparam logic [7:0]  REG_SEL    = 8'h08;
	localparam logic [7:0]  REG_CODE   = 8'h0C;
	localparam logic        CTRL_RESET = 1'h1;
	localparam logic [5:0]  SEL_RESET  = 6'h00;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_ACQ      = 2'h0,
		MODE_LOAD     = 2'h1,
		MODE_ACQ_READ = 2'h2,
		MODE_READ     = 2'h3
	} mode_t;

	typedef struct packed {
		mode_t      mode;
		logic       broadcast;
		logic       offset_sel;
		logic       test;
		logic [4:0] channel_address;
	} cmd_t;

	typedef struct packed {
		logic       sclk;
		logic       sync_n;
		logic       din;
		logic       interface_select;
		logic       wr_n;
		logic       par_offset_sel;
		logic       par_broadcast;
		logic [4:0] channel_address;
	} pins_t;

	typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_CODE, ST_READ, ST_DONE} ser_state_t;
endpackage
`default_nettype wire

// >>> dac_serial_port.sv
// Serial and parallel control port of a 32-channel converter, with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module dac_serial_port
	import dac_port_pkg::*;
#(
	parameter int unsigned ACQ_ALL_CYCLES = ACQ_ALL_CYCLES_DEF
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        sclk,
	input  wire logic        sync_n,
	input  wire logic        din,
	output logic             dout,
	output logic             dout_oe_n,
	input  wire logic        interface_select,
	input  wire logic        wr_n,
	input  wire logic [4:0]  channel_address,
	input  wire logic        par_offset_sel,
	input  wire logic        par_broadcast,
	output logic             acq_start,
	output logic [5:0]       acq_target,
	output logic             acq_all,
	output logic             acq_busy
);
	// Pin synchronisers; the first stage feeds only the second
	pins_t pin_m, pin_s, pin_p;
	always_ff @(posedge aclk) begin
		pin_m <= {sclk, sync_n, din, interface_select, wr_n, par_offset_sel,
			par_broadcast, channel_address};
		pin_s <= pin_m;
		pin_p <= pin_s;
	end
	// Edges seen by the fast clock, so a gated serial clock needs no own domain
	logic sclk_rise, sclk_fall, sync_fall, wr_rise, ser_en, par_wr, ctrl_q, ctrl_d;
	assign sclk_rise = pin_s.sclk && !pin_p.sclk;
	assign sclk_fall = !pin_s.sclk && pin_p.sclk;
	assign sync_fall = !pin_s.sync_n && pin_p.sync_n;
	assign wr_rise   = pin_s.wr_n && !pin_p.wr_n;
	assign ser_en    = pin_s.interface_select && ctrl_q;
	assign par_wr    = wr_rise && !pin_s.sync_n && !pin_s.interface_select;
	logic [CODE_BITS-1:0] code_q [NUM_REGS];
	logic                 ld_en, ld_all;
	logic [5:0]           ld_idx;
	logic [CODE_BITS-1:0] ld_val;
	for (genvar g = 0; g < NUM_REGS; g++) begin : g_code
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				code_q[g] <= '0;
			end else if (ld_en && ((ld_all && g < NUM_CONV) || (!ld_all && ld_idx == 6'(g)))) begin
				code_q[g] <= ld_all ? {CODE_BITS{ld_val[CODE_BITS-1]}} : ld_val;
			end
		end
	end
	ser_state_t  st_q, st_d;
	logic [4:0]  cnt_q, cnt_d;
	logic [23:0] sh_q, sh_d;
	cmd_t        cmd_q, cmd_d, cmd_next;
	logic        rd_pend_q, rd_pend_d;
	logic [5:0]  rd_idx_q, rd_idx_d;
	logic        dout_q, dout_d, oe_n_q, oe_n_d;
	logic        ser_acq;
	logic [5:0]  cmd_target;
	assign cmd_next   = cmd_t'({sh_q[8:0], pin_s.din});
	assign cmd_target = cmd_next.offset_sel ? OFFSET_CH
		: {1'b0, cmd_next.channel_address};
	always_comb begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		sh_d      = sh_q;
		cmd_d     = cmd_q;
		rd_pend_d = rd_pend_q;
		rd_idx_d  = rd_idx_q;
		dout_d    = dout_q;
		oe_n_d    = oe_n_q;
		ld_en     = 1'b0;
		ld_all    = cmd_q.broadcast;
		ld_idx    = cmd_q.offset_sel ? OFFSET_CH : {1'b0, cmd_q.channel_address};
		ld_val    = {sh_q[CODE_BITS-2:0], pin_s.din};
		ser_acq   = 1'b0;
		unique case (st_q)
			ST_IDLE, ST_DONE: begin
				if (sync_fall && ser_en) begin
					cnt_d     = '0;
					st_d      = rd_pend_q ? ST_READ : ST_CMD;
					rd_pend_d = 1'b0;
					sh_d      = {10'h000, code_q[rd_idx_q]};
				end
			end
			ST_CMD: begin
				if (sclk_fall) begin
					sh_d  = {sh_q[22:0], pin_s.din};
					cnt_d = 5'(cnt_q + 5'h01);
					if (cnt_q == CMD_LAST) begin
						cmd_d = cmd_next;
						if (cmd_next.mode == MODE_LOAD) begin
							st_d = ST_CODE;
						end else begin
							st_d      = ST_DONE;
							ser_acq   = !cmd_next.mode[0];
							rd_pend_d = cmd_next.mode[1];
							rd_idx_d  = cmd_target;
						end
					end
				end
			end
			ST_CODE: begin
				if (sclk_fall) begin
					sh_d  = {sh_q[22:0], pin_s.din};
					cnt_d = 5'(cnt_q + 5'h01);
					if (cnt_q == LOAD_LAST) begin
						ld_en = 1'b1;
						st_d  = ST_DONE;
					end
				end
			end
			ST_READ: begin
				if (sclk_rise) begin
					oe_n_d = 1'b0;
					dout_d = sh_q[CODE_BITS-1];
					sh_d   = {sh_q[22:0], 1'b0};
				end else if (sclk_fall) begin
					cnt_d = 5'(cnt_q + 5'h01);
					if (cnt_q == READ_LAST) begin
						oe_n_d = 1'b1;
						st_d   = ST_DONE;
					end
				end
			end
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q      <= ST_IDLE;
			cnt_q     <= '0;
			sh_q      <= '0;
			cmd_q     <= '0;
			rd_pend_q <= 1'b0;
			rd_idx_q  <= '0;
			dout_q    <= 1'b0;
			oe_n_q    <= 1'b1;
		end else begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			sh_q      <= sh_d;
			cmd_q     <= cmd_d;
			rd_pend_q <= rd_pend_d;
			rd_idx_q  <= rd_idx_d;
			dout_q    <= dout_d;
			oe_n_q    <= oe_n_d;
		end
	end
	assign dout      = dout_q;
	assign dout_oe_n = oe_n_q;
	// Acquisition request and busy timer
	logic        start_d, all_d, busy_d;
	logic [5:0]  tgt_d;
	logic [15:0] acq_cnt_q, acq_cnt_d;
	always_comb begin
		start_d   = 1'b0;
		tgt_d     = acq_target;
		all_d     = acq_all;
		acq_cnt_d = (acq_cnt_q != 16'h0000) ? 16'(acq_cnt_q - 16'h0001) : acq_cnt_q;
		if (ser_acq) begin
			start_d = 1'b1;
			tgt_d   = cmd_target;
			all_d   = cmd_next.broadcast;
		end else if (par_wr) begin
			start_d = 1'b1;
			tgt_d   = pin_s.par_offset_sel ? OFFSET_CH : {1'b0, pin_s.channel_address};
			all_d   = pin_s.par_broadcast;
		end
		if (start_d) begin
			// Broadcast acquisition is slower; the count is shortenable in simulation
			acq_cnt_d = all_d ? 16'(ACQ_ALL_CYCLES - 1) : 16'(ACQ_ONE_CYCLES - 1);
		end
		busy_d = start_d || (acq_cnt_d != 16'h0000);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acq_start  <= 1'b0;
			acq_target <= '0;
			acq_all    <= 1'b0;
			acq_busy   <= 1'b0;
			acq_cnt_q  <= '0;
		end else begin
			acq_start  <= start_d;
			acq_target <= tgt_d;
			acq_all    <= all_d;
			acq_busy   <= busy_d;
			acq_cnt_q  <= acq_cnt_d;
		end
	end
	// AXI4-Lite slave; address and data are taken together in one cycle
	logic        wr_go, rd_go, bvalid_d, rvalid_d;
	logic [1:0]  bresp_d, rresp_d;
	logic [31:0] rdata_d;
	logic [5:0]  sel_q, sel_d;
	assign awready = awvalid && wvalid && !bvalid;
	assign wready  = awready;
	assign wr_go   = awready;
	assign arready = !rvalid;
	assign rd_go   = arvalid && arready;
	always_comb begin
		ctrl_d   = ctrl_q;
		sel_d    = sel_q;
		bvalid_d = bvalid && !bready;
		bresp_d  = bresp;
		rvalid_d = rvalid && !rready;
		rresp_d  = rresp;
		rdata_d  = rdata;
		if (wr_go) begin
			bvalid_d = 1'b1;
			bresp_d  = RESP_OKAY;
			if (awaddr == REG_CTRL) begin
				if (wstrb[0]) ctrl_d = wdata[0];
			end else if (awaddr == REG_SEL) begin
				if (wstrb[0]) sel_d = wdata[5:0];
			end else if (awaddr != REG_STATUS && awaddr != REG_CODE) begin
				bresp_d = RESP_SLVERR;
			end
		end
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			unique case (araddr)
				REG_CTRL:   rdata_d = {31'h00000000, ctrl_q};
				REG_STATUS: rdata_d = {10'h000, rd_idx_q, 6'h00, cmd_q.mode, 4'h0,
					pin_s.interface_select, (st_q != ST_IDLE && st_q != ST_DONE),
					rd_pend_q, acq_busy};
				REG_SEL:    rdata_d = {26'h0000000, sel_q};
				REG_CODE:   rdata_d = (sel_q < OFFSET_CH + 6'h01)
					? {18'h00000, code_q[sel_q]} : 32'h00000000;
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			sel_q  <= SEL_RESET;
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp  <= RESP_OKAY;
			rdata  <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			sel_q  <= sel_d;
			bvalid <= bvalid_d;
			bresp  <= bresp_d;
			rvalid <= rvalid_d;
			rresp  <= rresp_d;
			rdata  <= rdata_d;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_sync_start_cmd: assert property (
		st_q == ST_IDLE && sync_fall && ser_en && !rd_pend_q |=> st_q == ST_CMD && cnt_q == 5'h00)
		else $error("sync fall did not start a command");
	chk_cmd_holds_count: assert property (
		st_q == ST_CMD && !sclk_fall |=> st_q == ST_CMD && $stable(cnt_q))
		else $error("command state moved without a clock fall");
	chk_done_ignores_clock: assert property (
		st_q == ST_DONE && !sync_fall |=> st_q == ST_DONE)
		else $error("finished transfer left done without sync");
	chk_load_mode_only: assert property (
		ld_en |-> st_q == ST_CODE && cmd_q.mode == MODE_LOAD && cnt_q == LOAD_LAST)
		else $error("register load outside load mode");
	chk_broadcast_fill: assert property (
		ld_en && ld_all && ld_val[CODE_BITS-1]
		|=> code_q[0] == {CODE_BITS{1'b1}} && code_q[NUM_CONV-1] == {CODE_BITS{1'b1}})
		else $error("broadcast load did not fill registers");
	chk_offset_target: assert property (
		ld_en && !ld_all && cmd_q.offset_sel |=> code_q[OFFSET_CH] == $past(ld_val))
		else $error("offset select did not reach offset register");
	chk_oe_first_rise: assert property (
		st_q == ST_READ && sclk_rise |=> !dout_oe_n ##0 dout == $past(sh_q[CODE_BITS-1]))
		else $error("readback output not driven on rise");
	chk_oe_release: assert property (
		st_q == ST_READ && sclk_fall && cnt_q == READ_LAST |=> dout_oe_n && st_q == ST_DONE)
		else $error("readback output not released");
	chk_par_capture: assert property (
		par_wr && !pin_s.par_offset_sel && !ser_acq
		|=> acq_start && acq_target == {1'b0, $past(pin_s.channel_address)})
		else $error("parallel strobe did not capture address");
	chk_all_busy: assert property (
		start_d && all_d |=> acq_busy [*8])
		else $error("broadcast acquisition busy too short");
endmodule
`default_nettype wire

// >>> host_serial_model.sv
// Host serial port model: frames words, runs a gated clock, captures readback
`timescale 1ns/1ps
`default_nettype none
module host_serial_model
	import dac_port_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        dout,
	input  wire logic        dout_oe_n,
	output logic             sclk,
	output logic             sync_n,
	output logic             din,
	output logic [13:0]      rd_word,
	output logic             rd_done
);
	logic wire_lvl;

	// No pull resistor on the line: released, it shows the inverse of the last bit
	assign wire_lvl = dout_oe_n ? ~dout : dout;

	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		din = 1'b0;
		rd_word = 14'h0000;
		rd_done = 1'b0;
	end

	task automatic half();
		repeat (20) @(posedge aclk);
	endtask

	task automatic frame(input int n, input logic [23:0] w, input logic rd);
		@(posedge aclk);
		sync_n <= 1'b0;
		half();
		for (int i = 23; i > 23 - n; i--) begin
			sclk <= 1'b1;
			din <= rd ? ~din : w[i];
			half();
			rd_word <= {rd_word[12:0], wire_lvl};
			sclk <= 1'b0;
			half();
		end
		// Clock stands still outside frames
		sync_n <= 1'b1;
		din <= ~din;
		repeat (150) @(posedge aclk);
		rd_done <= rd;
		@(posedge aclk);
		rd_done <= 1'b0;
	endtask

	task automatic send10(input cmd_t c);
		frame(10, {c, 14'h0000}, 1'b0);
	endtask

	task automatic send24(input cmd_t c, input logic [13:0] d);
		frame(24, {c, d}, 1'b0);
	endtask

	task automatic read14();
		frame(14, 24'h000000, 1'b1);
	endtask

	task automatic select(input logic v);
		@(posedge aclk);
		sync_n <= v;
	endtask
endmodule
`default_nettype wire

// >>> multichannel_dac_serial_port_test.sv
// Self-checking bench for the converter control port
`timescale 1ns/1ps
`default_nettype none
module multichannel_dac_serial_port_test
	import dac_port_pkg::*;
;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, sclk, sync_n, din, dout, dout_oe_n;
	logic        interface_select, wr_n, par_offset_sel, par_broadcast;
	logic        acq_start, acq_all, acq_busy, rd_done;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [4:0]  channel_address, ch;
	logic [5:0]  acq_target;
	logic [13:0] rd_word, code, keep;
	logic [33:0] rd_q[$];
	logic [6:0]  acq_q[$];
	logic [13:0] rb_q[$];
	logic [1:0]  wr_q[$];
	int          num_errors = 0;
	int          cmp_count = 0;

	dac_serial_port #(.ACQ_ALL_CYCLES(20)) dac_serial_port_i (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .sclk, .sync_n, .din, .dout, .dout_oe_n, .interface_select, .wr_n,
		.channel_address, .par_offset_sel, .par_broadcast, .acq_start, .acq_target,
		.acq_all, .acq_busy);

	host_serial_model host_serial_model_i (.aclk, .dout, .dout_oe_n, .sclk, .sync_n,
		.din, .rd_word, .rd_done);

	always #2 aclk = ~aclk;

	task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Results are matched against the oldest note of their kind
	always @(negedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1)
			cmp({rresp, rresp === RESP_OKAY ? rdata : 32'h0}, rd_q.pop_front(), "read");
		if (acq_start === 1'b1)
			cmp({27'h0, acq_target, acq_all}, {27'h0, acq_q.pop_front()}, "acquire");
		if (rd_done === 1'b1)
			cmp({20'h0, rd_word}, {20'h0, rb_q.pop_front()}, "readback");
		if (bvalid === 1'b1 && bready === 1'b1)
			cmp({32'h0, bresp}, {32'h0, wr_q.pop_front()}, "write response");
		if (acq_start === 1'b1)
			cmp({33'h0, acq_busy}, 34'h1, "busy at start");
	end

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		wr_q.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(negedge aclk); while (awready !== 1'b1);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(negedge aclk); while (bvalid !== 1'b1);
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		rd_q.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	task automatic chk_code(input logic [5:0] sel, input logic [13:0] c);
		axi_wr(REG_SEL, {26'h0, sel}, RESP_OKAY);
		axi_rd(REG_CODE, {18'h0, c}, RESP_OKAY);
	endtask

	task automatic wait_idle();
		do @(negedge aclk); while (acq_busy !== 1'b0);
	endtask

	task automatic readback(input cmd_t c, input logic [13:0] exp);
		host_serial_model_i.send10(c);
		rb_q.push_back(exp);
		wait_idle();
		host_serial_model_i.read14();
		cmp({33'h0, dout_oe_n}, 34'h1, "output enable");
	endtask

	function automatic cmd_t mk(mode_t m, logic b, logic o, logic [4:0] a);
		return '{m, b, o, 1'b0, a};
	endfunction

	task automatic report_and_stop();
		if (rd_q.size() + acq_q.size() + rb_q.size() + wr_q.size() != 0) num_errors++;
		$display("Comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge aclk);
		num_errors++;
		$display("ERROR %0t watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata, channel_address} = 53'h0;
		{par_offset_sel, par_broadcast, wr_n, interface_select} = 4'h3;
		wstrb = 4'hF;
		void'($urandom(84));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
		axi_rd(8'h40, 32'h0, RESP_SLVERR);
		axi_rd(REG_STATUS, 32'h8, RESP_OKAY);
		axi_wr(8'h40, 32'h1, RESP_SLVERR);
		axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
		for (int k = 0; k < 3; k++) begin
			ch = k == 0 ? 5'h00 : k == 1 ? 5'h1F : 5'($urandom);
			code = 14'($urandom);
			host_serial_model_i.send24(mk(MODE_LOAD, 1'b0, 1'b0, ch), code);
			chk_code({1'b0, ch}, code);
			readback(mk(MODE_READ, 1'b0, 1'b0, ch), code);
		end
		keep = 14'($urandom);
		host_serial_model_i.send24(mk(MODE_LOAD, 1'b0, 1'b1, 5'h15), keep);
		chk_code(OFFSET_CH, keep);
		host_serial_model_i.send24(mk(MODE_LOAD, 1'b1, 1'b0, ch), 14'h2000 | code);
		chk_code(6'h07, 14'h3FFF);
		host_serial_model_i.send24(mk(MODE_LOAD, 1'b1, 1'b0, ch), 14'h1FFF & code);
		chk_code(6'h1F, 14'h0000);
		readback(mk(MODE_READ, 1'b0, 1'b1, 5'h0A), keep);
		// Extra clocks after a short command must change nothing
		acq_q.push_back({1'b0, ch, 1'b0});
		host_serial_model_i.send24(mk(MODE_ACQ, 1'b0, 1'b0, ch), 14'h3FFF);
		chk_code({1'b0, ch}, 14'h0000);
		for (int i = 0; i < 3; i++) begin
			ch = 5'($urandom);
			wait_idle();
			acq_q.push_back({i == 2 ? OFFSET_CH : {1'b0, ch}, i == 1});
			host_serial_model_i.send10(mk(MODE_ACQ, i == 1, i == 2, ch));
		end
		wait_idle();
		acq_q.push_back({1'b0, ch, 1'b0});
		readback(mk(MODE_ACQ_READ, 1'b0, 1'b0, ch), 14'h0000);
		@(posedge aclk);
		interface_select <= 1'b0;
		host_serial_model_i.select(1'b0);
		for (int i = 0; i < 3; i++) begin
			wait_idle();
			ch = 5'($urandom);
			acq_q.push_back({i == 1 ? OFFSET_CH : {1'b0, ch}, i == 2});
			@(posedge aclk);
			channel_address <= ch;
			par_offset_sel <= i == 1;
			par_broadcast <= i == 2;
			wr_n <= 1'b0;
			repeat (5) @(posedge aclk);
			wr_n <= 1'b1;
			repeat (10) @(posedge aclk);
			channel_address <= ~ch;
		end
		wait_idle();
		host_serial_model_i.select(1'b1);
		host_serial_model_i.send24(mk(MODE_LOAD, 1'b0, 1'b0, 5'h03), 14'h1234);
		chk_code(6'h03, 14'h0000);
		interface_select <= 1'b1;
		axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
		host_serial_model_i.send24(mk(MODE_LOAD, 1'b0, 1'b0, 5'h03), 14'h1234);
		chk_code(6'h03, 14'h0000);
		axi_rd(REG_CTRL, 32'h0, RESP_OKAY);
		repeat (20) @(posedge aclk);
		report_and_stop();
	end
endmodule
`default_nettype wire
